// ---- mxu_exc_sva.sv ----
// Checker for the translation exception unit
`timescale 1ns/1ns
module mxu_exc_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs watched
    input wire logic avs_write,
    input wire logic acc_valid,
    input wire logic acc_fetch,
    input wire logic acc_write,
    input wire logic [3:0] acc_cache_op,
    input wire logic [3:0] ftlb_hit_vec,
    input wire logic [63:0] mtlb_hit_vec,
    input wire logic load_tlb_instr,
    input wire logic exception_return_instr,
    // Outputs watched
    input wire logic exc_taken,
    input wire logic [11:0] exc_code,
    input wire logic redirect_valid,
    input wire logic [31:0] redirect_addr,
    input wire logic [31:0] status_out,
    input wire logic ftlb_fill,
    input wire logic mtlb_load
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
wire dwr = (acc_cache_op[3:2] != 2'b00) || (acc_cache_op == 4'h0 && acc_write);
////////////////////////////////////////////////////////////////////////////////
// Status seen by this access is open
sequence s_open;
    !status_out[28] && !exc_taken && !$past(avs_write) && !$past(exception_return_instr);
endsequence
sequence s_fetch_multi;
    acc_valid && acc_fetch && ($countones(ftlb_hit_vec) > 1 ||
        (ftlb_hit_vec == 4'h0 && $countones(mtlb_hit_vec) > 1));
endsequence
sequence s_data_miss;
    acc_valid && !acc_fetch && mtlb_hit_vec == 64'h0;
endsequence
a_ifetch_multi: assert property (s_open ##0 s_fetch_multi |=> exc_taken && exc_code == 12'h140)
    else $error("instruction multi hit not reported");
a_data_multi: assert property (s_open ##0 (acc_valid && !acc_fetch && $countones(mtlb_hit_vec) > 1)
    |=> exc_taken && exc_code == 12'h140) else $error("data multi hit not reported");
a_multi_target: assert property (exc_taken && exc_code == 12'h140 |-> redirect_addr == 32'ha000_0000)
    else $error("multi hit target wrong");
a_imiss_code: assert property (s_open ##0 (acc_valid && acc_fetch && ftlb_hit_vec == 4'h0 &&
    mtlb_hit_vec == 64'h0) |=> exc_taken && exc_code == 12'h040) else $error("fetch miss code wrong");
a_dmiss_code: assert property (s_open ##0 s_data_miss |=> exc_taken &&
    exc_code == ($past(dwr) ? 12'h060 : 12'h040)) else $error("data miss code wrong");
a_refill_quiet: assert property (acc_valid && acc_fetch && ftlb_hit_vec == 4'h0 &&
    $onehot(mtlb_hit_vec) |=> ftlb_fill && !exc_taken) else $error("refill wrong");
a_block_mask: assert property (acc_valid && status_out[28] && !$past(avs_write) &&
    !$past(exception_return_instr) |=> !exc_taken) else $error("exception not masked");
a_flags_set: assert property (exc_taken && exc_code != 12'h140 |=> status_out[30:28] == 3'b111)
    else $error("status flags not set");
a_pulse_pair: assert property (exc_taken == redirect_valid)
    else $error("redirect not paired");
a_one_report: assert property (exc_taken |-> !ftlb_fill && $countones(exc_code) > 0)
    else $error("two outcomes for one access");
a_load_pulse: assert property (load_tlb_instr |=> mtlb_load)
    else $error("tlb load missing");
endmodule
bind mxu_exception_unit mxu_exc_sva u_sva (.clk, .rst, .avs_write, .acc_valid, .acc_fetch, .acc_write,
    .acc_cache_op, .ftlb_hit_vec, .mtlb_hit_vec, .load_tlb_instr, .exception_return_instr, .exc_taken,
    .exc_code, .redirect_valid, .redirect_addr, .status_out, .ftlb_fill, .mtlb_load);

// ---- mxu_exception_unit.v ----
// Translation exception unit: detection, state capture, redirect and TLB load
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "mxu_regs.vh"

module mxu_exception_unit (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Avalon-MM register slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Access from the pipeline
    input wire acc_valid,
    input wire acc_fetch,
    input wire acc_write,
    input wire [3:0] acc_cache_op,
    input wire [31:0] acc_vaddr,
    input wire [31:0] acc_pc,
    input wire acc_delay_slot,
    input wire [31:0] acc_branch_pc,
    input wire [31:0] stack_pointer_reg,
    // Lookup results
    input wire [3:0] ftlb_hit_vec,
    input wire [7:0] ftlb_right_vec,
    input wire [63:0] mtlb_hit_vec,
    input wire [127:0] mtlb_right_vec,
    input wire [63:0] mtlb_dirty_vec,
    // Instruction stream controls
    input wire load_tlb_instr,
    input wire exception_return_instr,
    // Exception report
    output reg exc_taken,
    output reg [11:0] exc_code,
    output reg redirect_valid,
    output reg [31:0] redirect_addr,
    output reg [31:0] status_out,
    // Instruction TLB refill
    output reg ftlb_fill,
    output reg [5:0] ftlb_fill_src,
    // Unified TLB load
    output reg mtlb_load,
    output reg [5:0] mtlb_load_idx,
    output reg [31:0] mtlb_load_high,
    output reg [31:0] mtlb_load_low
);
    // Cache operation kinds on acc_cache_op
    localparam [3:0] OP_PURGE = 4'h1;
    localparam [3:0] OP_WRITEBACK = 4'h2;
    localparam [3:0] OP_INVALIDATE = 4'h4;
    localparam [3:0] OP_ALLOC_STORE = 4'h8;

    reg [31:0] fault_address_reg;
    reg [31:0] exception_event_reg;
    reg [31:0] entry_high_reg;
    reg [31:0] entry_low_reg;
    reg [31:0] saved_pc;
    reg [31:0] saved_status;
    reg [31:0] saved_stack_reg;
    reg [31:0] processor_status;
    reg [31:0] vector_base;
    reg [5:0] replace_counter;
    reg [5:0] replace_boundary;

    wire i_any;
    wire i_multi;
    wire [1:0] i_right;
    wire u_any;
    wire u_multi;
    wire [5:0] u_idx;
    wire [1:0] u_right;
    wire u_dirty;

    ////////////////////////////////////////////////////////////////////////
    // Match reduction
    mxu_hit_sel #(.N(`MXU_FTLB_ENTRIES), .IW(`MXU_FTLB_IDX_W)) u_ftlb_sel (
        .hit_vec(ftlb_hit_vec),
        .right_vec(ftlb_right_vec),
        .dirty_vec(4'h0),
        .any_hit(i_any),
        .multi_hit(i_multi),
        .hit_idx(),
        .hit_right(i_right),
        .hit_dirty()
    );

    mxu_hit_sel #(.N(`MXU_MTLB_ENTRIES), .IW(`MXU_MTLB_IDX_W)) u_mtlb_sel (
        .hit_vec(mtlb_hit_vec),
        .right_vec(mtlb_right_vec),
        .dirty_vec(mtlb_dirty_vec),
        .any_hit(u_any),
        .multi_hit(u_multi),
        .hit_idx(u_idx),
        .hit_right(u_right),
        .hit_dirty(u_dirty)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access right decode
    wire priv = processor_status[`MXU_ST_PRIV];
    wire blocked = processor_status[`MXU_ST_BLOCK];
    wire is_wr = acc_write | (acc_cache_op == OP_INVALIDATE) | (acc_cache_op == OP_ALLOC_STORE);

    function right_ok;
        input [1:0] right;
        input wr;
        input pv;
        begin
            case (right)
                2'h0: right_ok = pv & ~wr;
                2'h1: right_ok = pv;
                2'h2: right_ok = ~wr;
                default: right_ok = 1'b1;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Exception classification
    reg [11:0] next_code;
    reg next_exc;
    reg next_multi;
    reg [31:0] next_vec_ofs;
    reg next_refill;

    always @* begin
        next_code = 12'h000;
        next_exc = 1'b0;
        next_multi = 1'b0;
        next_vec_ofs = `MXU_OFS_GENERAL_VEC;
        next_refill = 1'b0;
        if (acc_valid && acc_fetch) begin
            if (i_any) begin
                if (i_multi) begin
                    next_exc = 1'b1;
                    next_multi = 1'b1;
                end else if (!right_ok(i_right, 1'b0, priv)) begin
                    next_exc = 1'b1;
                    next_code = `MXU_CODE_PROT_READ;
                    next_vec_ofs = `MXU_OFS_GENERAL_VEC;
                end
            end else if (u_multi) begin
                next_exc = 1'b1;
                next_multi = 1'b1;
            end else if (u_any) begin
                next_refill = 1'b1;
            end else begin
                next_exc = 1'b1;
                next_code = `MXU_CODE_MISS_READ;
                next_vec_ofs = `MXU_OFS_MISS_VEC;
            end
        end else if (acc_valid) begin
            if (u_multi) begin
                next_exc = 1'b1;
                next_multi = 1'b1;
            end else if (!u_any) begin
                next_exc = 1'b1;
                next_code = is_wr ? `MXU_CODE_MISS_WRITE : `MXU_CODE_MISS_READ;
                next_vec_ofs = `MXU_OFS_MISS_VEC;
            end else if (!right_ok(u_right, is_wr, priv)) begin
                next_exc = 1'b1;
                next_code = is_wr ? `MXU_CODE_PROT_WRITE : `MXU_CODE_PROT_READ;
            end else if (is_wr && !u_dirty) begin
                next_exc = 1'b1;
                next_code = `MXU_CODE_FIRST_WRITE;
            end
        end
        if (next_multi) begin
            next_code = `MXU_CODE_MULTI_HIT;
        end
        if (blocked) begin
            next_exc = 1'b0;
            next_multi = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux and byte lane merge
    reg [31:0] rd_mux;

    always @* begin
        case (avs_address)
            `MXU_OFS_FAULT_ADDR: rd_mux = fault_address_reg;
            `MXU_OFS_EVENT: rd_mux = exception_event_reg;
            `MXU_OFS_ENTRY_HIGH: rd_mux = entry_high_reg;
            `MXU_OFS_ENTRY_LOW: rd_mux = entry_low_reg;
            `MXU_OFS_SAVED_PC: rd_mux = saved_pc;
            `MXU_OFS_SAVED_STATUS: rd_mux = saved_status;
            `MXU_OFS_SAVED_STACK: rd_mux = saved_stack_reg;
            `MXU_OFS_STATUS: rd_mux = processor_status;
            `MXU_OFS_VECTOR_BASE: rd_mux = vector_base;
            `MXU_OFS_MMU_CONTROL: rd_mux = {8'h00, replace_boundary, 2'h0, replace_counter, 10'h000};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[8*k +: 8] = wd[8*k +: 8];
                end
            end
        end
    endfunction

    wire bus_wr = avs_write && !avs_waitrequest;
    wire [31:0] ctl_new = merge(rd_mux, avs_writedata, avs_byteenable);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake, one wait cycle per access
    always @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            if (avs_waitrequest && (avs_read || avs_write)) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file, hardware updates win over software writes
    always @(posedge clk) begin
        if (rst) begin
            fault_address_reg <= 32'h0000_0000;
            exception_event_reg <= 32'h0000_0000;
            entry_high_reg <= 32'h0000_0000;
            entry_low_reg <= 32'h0000_0000;
            saved_pc <= 32'h0000_0000;
            saved_status <= 32'h0000_0000;
            saved_stack_reg <= 32'h0000_0000;
            processor_status <= `MXU_STATUS_RESET;
            vector_base <= 32'h0000_0000;
            replace_counter <= 6'h00;
            replace_boundary <= 6'h3f;
        end else begin
            if (bus_wr) begin
                case (avs_address)
                    `MXU_OFS_FAULT_ADDR: fault_address_reg <= ctl_new;
                    `MXU_OFS_EVENT: exception_event_reg <= ctl_new;
                    `MXU_OFS_ENTRY_HIGH: entry_high_reg <= ctl_new;
                    `MXU_OFS_ENTRY_LOW: entry_low_reg <= ctl_new;
                    `MXU_OFS_SAVED_PC: saved_pc <= ctl_new;
                    `MXU_OFS_SAVED_STATUS: saved_status <= ctl_new;
                    `MXU_OFS_SAVED_STACK: saved_stack_reg <= ctl_new;
                    `MXU_OFS_STATUS: processor_status <= ctl_new;
                    `MXU_OFS_VECTOR_BASE: vector_base <= ctl_new;
                    `MXU_OFS_MMU_CONTROL: begin
                        replace_counter <= ctl_new[`MXU_CTL_RCNT_LSB +: 6];
                        replace_boundary <= ctl_new[`MXU_CTL_RBND_LSB +: 6];
                    end
                    default: begin
                    end
                endcase
            end
            if (load_tlb_instr) begin
                replace_counter <= (replace_counter == replace_boundary) ? 6'h00 : replace_counter + 6'h01;
            end
            if (exception_return_instr) begin
                processor_status <= saved_status;
            end
            if (next_exc) begin
                fault_address_reg <= acc_vaddr;
                exception_event_reg <= {20'h00000, next_code};
            end
            if (next_exc && !next_multi) begin
                entry_high_reg[31:`MXU_PAGE_LSB] <= acc_vaddr[31:`MXU_PAGE_LSB];
                saved_pc <= acc_delay_slot ? acc_branch_pc : acc_pc;
                saved_status <= processor_status;
                saved_stack_reg <= stack_pointer_reg;
                processor_status[`MXU_ST_PRIV] <= 1'b1;
                processor_status[`MXU_ST_BLOCK] <= 1'b1;
                processor_status[`MXU_ST_BANK] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Report, redirect and TLB write strobes
    always @(posedge clk) begin
        if (rst) begin
            exc_taken <= 1'b0;
            exc_code <= 12'h000;
            redirect_valid <= 1'b0;
            redirect_addr <= 32'h0000_0000;
            status_out <= `MXU_STATUS_RESET;
            ftlb_fill <= 1'b0;
            ftlb_fill_src <= 6'h00;
            mtlb_load <= 1'b0;
            mtlb_load_idx <= 6'h00;
            mtlb_load_high <= 32'h0000_0000;
            mtlb_load_low <= 32'h0000_0000;
        end else begin
            exc_taken <= next_exc;
            exc_code <= next_exc ? next_code : 12'h000;
            redirect_valid <= next_exc;
            if (next_multi) begin
                redirect_addr <= `MXU_RESET_ADDR;
            end else if (next_exc) begin
                redirect_addr <= vector_base + next_vec_ofs;
            end
            status_out <= processor_status;
            ftlb_fill <= next_refill;
            ftlb_fill_src <= u_idx;
            mtlb_load <= load_tlb_instr;
            if (load_tlb_instr) begin
                mtlb_load_idx <= replace_counter;
                mtlb_load_high <= entry_high_reg;
                mtlb_load_low <= entry_low_reg;
            end
        end
    end
endmodule

// ---- mxu_hit_sel.v ----
// Match vector reduction: any hit, multiple hits, index and fields of the hit
`timescale 1ns/1ns
module mxu_hit_sel #(
    parameter N = 4,
    parameter IW = 2
) (
    // Per-entry match results and fields
    input wire [N-1:0] hit_vec,
    input wire [2*N-1:0] right_vec,
    input wire [N-1:0] dirty_vec,
    // Reduced result
    output wire any_hit,
    output wire multi_hit,
    output wire [IW-1:0] hit_idx,
    output wire [1:0] hit_right,
    output wire hit_dirty
);
    wire [N:0] seen;
    wire [N:0] multi;
    wire [IW*(N+1)-1:0] idx_acc;
    wire [2*(N+1)-1:0] right_acc;
    wire [N:0] dirty_acc;

    assign seen[0] = 1'b0;
    assign multi[0] = 1'b0;
    assign idx_acc[IW-1:0] = {IW{1'b0}};
    assign right_acc[1:0] = 2'h0;
    assign dirty_acc[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_ent
            wire [31:0] my_num;
            wire [IW-1:0] my_idx;
            assign my_num = i;
            assign my_idx = my_num[IW-1:0];
            assign seen[i+1] = seen[i] | hit_vec[i];
            assign multi[i+1] = multi[i] | (seen[i] & hit_vec[i]);
            assign idx_acc[IW*(i+2)-1:IW*(i+1)] = idx_acc[IW*(i+1)-1:IW*i] | (hit_vec[i] ? my_idx : {IW{1'b0}});
            assign right_acc[2*i+3:2*i+2] = right_acc[2*i+1:2*i] | (hit_vec[i] ? right_vec[2*i+1:2*i] : 2'h0);
            assign dirty_acc[i+1] = dirty_acc[i] | (hit_vec[i] & dirty_vec[i]);
        end
    endgenerate

    assign any_hit = seen[N];
    assign multi_hit = multi[N];
    assign hit_idx = idx_acc[IW*(N+1)-1:IW*N];
    assign hit_right = right_acc[2*N+1:2*N];
    assign hit_dirty = dirty_acc[N];
endmodule

// ---- mxu_regs.vh ----
// Register map, field positions, codes and addresses of the exception unit
`ifndef MXU_REGS_VH
`define MXU_REGS_VH
`define MXU_OFS_FAULT_ADDR 6'h00
`define MXU_OFS_EVENT 6'h04
`define MXU_OFS_ENTRY_HIGH 6'h08
`define MXU_OFS_ENTRY_LOW 6'h0c
`define MXU_OFS_SAVED_PC 6'h10
`define MXU_OFS_SAVED_STATUS 6'h14
`define MXU_OFS_SAVED_STACK 6'h18
`define MXU_OFS_STATUS 6'h1c
`define MXU_OFS_VECTOR_BASE 6'h20
`define MXU_OFS_MMU_CONTROL 6'h24
`define MXU_ST_PRIV 30
`define MXU_ST_BANK 29
`define MXU_ST_BLOCK 28
`define MXU_STATUS_RESET 32'h7000_0000
`define MXU_CTL_RCNT_LSB 10
`define MXU_CTL_RBND_LSB 18
`define MXU_PAGE_LSB 10
`define MXU_CODE_MULTI_HIT 12'h140
`define MXU_CODE_MISS_READ 12'h040
`define MXU_CODE_MISS_WRITE 12'h060
`define MXU_CODE_PROT_READ 12'h0a0
`define MXU_CODE_PROT_WRITE 12'h0c0
`define MXU_CODE_FIRST_WRITE 12'h080
`define MXU_RESET_ADDR 32'ha000_0000
`define MXU_OFS_MISS_VEC 32'h0000_0400
`define MXU_OFS_GENERAL_VEC 32'h0000_0100
`define MXU_FTLB_ENTRIES 4
`define MXU_FTLB_IDX_W 2
`define MXU_MTLB_ENTRIES 64
`define MXU_MTLB_IDX_W 6
`endif

// ---- mxu_tlb_model.sv ----
// Lookup side model: hit vectors, rights and dirty bits per scenario
`timescale 1ns/1ns
module mxu_tlb_model (
    // Scenario knobs
    input wire logic [1:0] it_n,
    input wire logic [1:0] ut_n,
    input wire logic [1:0] right,
    input wire logic dirty,
    input wire logic [5:0] hidx,
    // Lookup results
    output logic [3:0] ftlb_hit_vec,
    output logic [7:0] ftlb_right_vec,
    output logic [63:0] mtlb_hit_vec,
    output logic [127:0] mtlb_right_vec,
    output logic [63:0] mtlb_dirty_vec
);
// Entries that miss carry inverted fields
always @* begin
    ftlb_hit_vec = 4'h0;
    mtlb_hit_vec = 64'h0;
    for (int i = 0; i < 3; i++) begin
        if (i < it_n) ftlb_hit_vec[(hidx + i) % 4] = 1'b1;
        if (i < ut_n) mtlb_hit_vec[(hidx + i) % 64] = 1'b1;
    end
    for (int i = 0; i < 64; i++) begin
        mtlb_right_vec[2*i +: 2] = mtlb_hit_vec[i] ? right : ~right;
        mtlb_dirty_vec[i] = mtlb_hit_vec[i] ? dirty : ~dirty;
        if (i < 4) ftlb_right_vec[2*i +: 2] = ftlb_hit_vec[i] ? right : ~right;
    end
end
endmodule

// ---- tb_top.sv ----
// Testbench of the translation exception unit
`timescale 1ns/1ns
module tb_top;
logic clk, rst, avs_read, avs_write, acc_valid, acc_fetch, acc_write, acc_delay_slot, dirty, p, blk, w;
logic load_tlb_instr, exception_return_instr;
logic [5:0] avs_address, hidx;
logic [31:0] avs_writedata, acc_vaddr, acc_pc, acc_branch_pc, stack_pointer_reg, rd, vb, st, ehi, elo;
logic [3:0] acc_cache_op, avs_byteenable;
logic [1:0] it_n, ut_n, right;
logic [11:0] ec;
wire [31:0] avs_readdata, redirect_addr, status_out, mtlb_load_high, mtlb_load_low;
wire avs_waitrequest, exc_taken, redirect_valid, ftlb_fill, mtlb_load;
wire [11:0] exc_code;
wire [5:0] ftlb_fill_src, mtlb_load_idx;
wire [3:0] ftlb_hit_vec;
wire [7:0] ftlb_right_vec;
wire [63:0] mtlb_hit_vec, mtlb_dirty_vec;
wire [127:0] mtlb_right_vec;
int n_fail, num_checks, cyc, k;
mxu_exception_unit dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .acc_valid, .acc_fetch, .acc_write,
    .acc_cache_op, .acc_vaddr, .acc_pc, .acc_delay_slot, .acc_branch_pc, .stack_pointer_reg,
    .ftlb_hit_vec, .ftlb_right_vec, .mtlb_hit_vec, .mtlb_right_vec, .mtlb_dirty_vec, .load_tlb_instr,
    .exception_return_instr, .exc_taken, .exc_code, .redirect_valid, .redirect_addr, .status_out,
    .ftlb_fill, .ftlb_fill_src, .mtlb_load, .mtlb_load_idx, .mtlb_load_high, .mtlb_load_low);
mxu_tlb_model tlb (.it_n, .ut_n, .right, .dirty, .hidx, .ftlb_hit_vec, .ftlb_right_vec, .mtlb_hit_vec,
    .mtlb_right_vec, .mtlb_dirty_vec);
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk = 0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        n_fail++;
        print_verdict();
    end
end
task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
        n_fail++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
// Avalon master: hold until waitrequest sampled low
task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
endtask
function logic [11:0] exp_code(input logic f, w, input logic [1:0] itn, utn, r, input logic d, pv);
    if (f) begin
        if (itn > 1 || (itn == 0 && utn > 1)) return 12'h140;
        if (itn == 1) return (pv || r[1]) ? 12'h000 : 12'h0a0;
        return utn == 1 ? 12'h000 : 12'h040;
    end
    if (utn > 1) return 12'h140;
    if (utn == 0) return w ? 12'h060 : 12'h040;
    if (!(pv || r[1]) || (w && !r[0])) return w ? 12'h0c0 : 12'h0a0;
    return (w && !d) ? 12'h080 : 12'h000;
endfunction
function logic [31:0] exp_tgt(input logic [11:0] c, input logic [31:0] base);
    if (c == 12'h140) return 32'ha000_0000;
    if (c == 12'h040 || c == 12'h060) return base + 32'h0000_0400;
    return base + 32'h0000_0100;
endfunction
initial begin
    {avs_read, avs_write, acc_valid, acc_fetch, acc_write, acc_delay_slot, load_tlb_instr} = 7'h00;
    {exception_return_instr, dirty, it_n, ut_n, right, hidx, acc_cache_op, avs_address} = 0;
    {avs_writedata, acc_vaddr, acc_pc, acc_branch_pc, stack_pointer_reg} = 0;
    avs_byteenable = 4'hf;
    {n_fail, num_checks, cyc} = 0;
    rst = 1'b1;
    void'($urandom(32'hca30));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, 6'h1c, 0, rd);
    chk(rd, 32'h7000_0000);
    bus(0, 6'h3c, 0, rd);
    chk(rd, 0);
    vb = $urandom & 32'hffff_f000;
    bus(1, 6'h20, vb, rd);
    // Handler fills entry registers and picks victim near boundary
    ehi = $urandom;
    elo = $urandom;
    bus(1, 6'h08, ehi, rd);
    bus(1, 6'h0c, elo, rd);
    // Partial lane write keeps the upper half of entry low
    avs_byteenable <= 4'h3;
    bus(1, 6'h0c, ~elo, rd);
    avs_byteenable <= 4'hf;
    elo[15:0] = ~elo[15:0];
    bus(1, 6'h24, (32'd6 << 18) | (32'd5 << 10), rd);
    load_tlb_instr <= 1'b1;
    for (k = 0; k < 4; k++) begin
        @(posedge clk);
        if (k == 2) load_tlb_instr <= 1'b0;
        if (k >= 1) begin
            chk(mtlb_load, 1);
            chk(mtlb_load_idx, k == 1 ? 5 : k == 2 ? 6 : 0);
            chk(mtlb_load_high, ehi);
            chk(mtlb_load_low, elo);
        end
    end
    bus(0, 6'h24, 0, rd);
    chk(rd[15:10], 1);
    chk(rd[23:18], 6);
    repeat (80) begin
        p = $urandom % 2;
        blk = ($urandom % 6) == 0;
        st = {1'b0, p, 1'b0, blk, 12'h000, 16'($urandom)};
        bus(1, 6'h1c, st, rd);
        acc_fetch <= $urandom % 2;
        @(posedge clk);
        k = $urandom % 5;
        acc_cache_op <= acc_fetch ? 4'h0 : (k == 0 ? 4'h0 : 4'h1 << (k - 1));
        w = acc_fetch ? 1'b0 : (k >= 3 ? 1'b1 : k == 0 ? 1'($urandom) : 1'b0);
        acc_write <= w;
        it_n <= $urandom % 3;
        ut_n <= $urandom % 3;
        right <= $urandom;
        dirty <= $urandom;
        hidx <= $urandom;
        acc_vaddr <= $urandom;
        acc_pc <= $urandom;
        acc_branch_pc <= $urandom;
        acc_delay_slot <= $urandom;
        stack_pointer_reg <= $urandom;
        acc_valid <= 1'b1;
        @(posedge clk);
        acc_valid <= 1'b0;
        ec = blk ? 12'h000 : exp_code(acc_fetch, w, it_n, ut_n, right, dirty, p);
        @(posedge clk);
        chk(exc_taken, ec != 0);
        chk(exc_code, ec);
        chk(ftlb_fill, acc_fetch && it_n == 0 && ut_n == 1);
        if (ftlb_fill === 1'b1) chk(ftlb_fill_src, hidx);
        if (ec != 0) begin
            chk(redirect_addr, exp_tgt(ec, vb));
            bus(0, 6'h00, 0, rd);
            chk(rd, acc_vaddr);
            bus(0, 6'h04, 0, rd);
            chk(rd, ec);
        end
        if (ec != 0 && ec != 12'h140) begin
            bus(0, 6'h08, 0, rd);
            chk(rd[31:10], acc_vaddr[31:10]);
            bus(0, 6'h10, 0, rd);
            chk(rd, acc_delay_slot ? acc_branch_pc : acc_pc);
            bus(0, 6'h14, 0, rd);
            chk(rd, st);
            bus(0, 6'h18, 0, rd);
            chk(rd, stack_pointer_reg);
            bus(0, 6'h1c, 0, rd);
            chk(rd, st | 32'h7000_0000);
            // Handler returns, status comes back from its saved copy
            exception_return_instr <= 1'b1;
            @(posedge clk);
            exception_return_instr <= 1'b0;
            @(posedge clk);
            bus(0, 6'h1c, 0, rd);
            chk(rd, st);
        end
    end
    print_verdict();
end
endmodule
